// ### src/i2c_ctrl_defs.svh
// constants of the parallel-host i2c controller
`ifndef I2C_CTRL_DEFS_SVH
`define I2C_CTRL_DEFS_SVH
`define OWN_ADDR_RESET   8'h00
`define CLK_REG_RESET    8'h00
`define VEC_RESET_SEP    8'h00
`define VEC_RESET_SINGLE 8'h0F
`define CTRL_RESET       8'h80
`define PRE_DIV_3M       6'h07
`define PRE_DIV_4M43     6'h0A
`define PRE_DIV_6M       6'h0D
`define PRE_DIV_8M       6'h13
`define PRE_DIV_12M      6'h1C
`define SCL_HALF_90K     10'h008
`define SCL_HALF_45K     10'h010
`define SCL_HALF_11K     10'h040
`define SCL_HALF_1K5     10'h1E0
`endif

// ### src/i2c_ctrl_pkg.sv
// types of the parallel-host i2c controller
package i2c_ctrl_pkg;
	typedef struct packed {
		logic pending_n;
		logic serial_enable;
		logic reg_select_1;
		logic reg_select_2;
		logic irq_enable;
		logic start_request;
		logic stop_request;
		logic ack_enable;
	} ctrl_s;
	typedef struct packed {
		logic       cs_n;
		logic       wr_n;
		logic       rd_n;
		logic       register_select;
		logic       irq_acknowledge_n;
		logic [7:0] data;
	} host_pins_s;
	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_SHIFT = 2'b01,
		S_ACKP  = 2'b11,
		S_HOLD  = 2'b10
	} byte_state_e;
	typedef enum logic [2:0] {
		T_CTRL, T_OWN, T_VEC, T_CLK, T_DATA, T_NONE
	} reg_target_e;
endpackage

// ### src/parallel_host_i2c_controller_regs.sv
// parallel host register file and byte engine of the i2c controller
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_defs.svh"
module parallel_host_i2c_controller_regs import i2c_ctrl_pkg::*; (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// host bus pins
	input  wire host_pins_s host_pins,
	output logic [7:0]      db_out,
	output logic            db_oe,
	output logic            transfer_ack_n_out,
	output logic            transfer_ack_n_oe,
	output logic            irq_out,
	output logic            irq_oe,
	// i2c pins
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe
);
	host_pins_s  pins1_q, pins_q;
	logic [1:0]  line1_q, line_q;
	logic        filt_q [2];
	logic        hist_q [2];
	ctrl_s       ctrl_q;
	logic [7:0]  own_q, clk_q, vec_q, sh_q, rbuf_q, db_out_q;
	logic        vec_written_q, single_q, wr_prev_q, acc_q, db_oe_q, tack_oe_q, irq_oe_q;
	logic        stop_det_q, gc_lrb_q, aas_q, bb_n_q, first_q, tx_q, scl_low_q, sda_low_q;
	logic [5:0]  pre_cnt_q;
	logic [9:0]  half_cnt_q;
	logic [2:0]  bit_q;
	byte_state_e state_q;
	logic        acc, acc_start, is_wr, irq_acknowledge_n_cyc, tick, half_end, byte_done, host_data_wr, host_data_rd;
	logic [7:0]  status, rdata;
	reg_target_e tgt;

	function automatic reg_target_e decode(input logic sel, input ctrl_s c);
		if (sel) begin
			decode = T_CTRL;
		end else if (c.serial_enable && !c.reg_select_1 && !c.reg_select_2) begin
			decode = T_DATA;
		end else if (!c.reg_select_1 && !c.reg_select_2) begin
			decode = T_OWN;
		end else if (!c.reg_select_1) begin
			decode = T_VEC;
		end else if (!c.serial_enable && !c.reg_select_2) begin
			decode = T_CLK;
		end else begin
			decode = T_NONE;
		end
	endfunction

	function automatic logic [5:0] pre_div(input logic [2:0] code);
		case (code)
			3'b100:  pre_div = `PRE_DIV_4M43;
			3'b101:  pre_div = `PRE_DIV_6M;
			3'b110:  pre_div = `PRE_DIV_8M;
			3'b111:  pre_div = `PRE_DIV_12M;
			default: pre_div = `PRE_DIV_3M;
		endcase
	endfunction

	function automatic logic [9:0] scl_half(input logic [1:0] code);
		case (code)
			2'b00:   scl_half = `SCL_HALF_90K;
			2'b01:   scl_half = `SCL_HALF_45K;
			2'b10:   scl_half = `SCL_HALF_11K;
			default: scl_half = `SCL_HALF_1K5;
		endcase
	endfunction

	// two-stage synchronisers for every pin input
	always_ff @(posedge core_clk) begin
		pins1_q <= host_pins;
		pins_q  <= pins1_q;
		line1_q <= {scl_in, sda_in};
		line_q  <= line1_q;
	end

	// access decode for both host styles
	always_comb begin
		acc       = !pins_q.cs_n && (single_q || !pins_q.wr_n || !pins_q.rd_n);
		acc_start = acc && !acc_q;
		is_wr     = !pins_q.wr_n;
		irq_acknowledge_n_cyc  = !pins_q.irq_acknowledge_n && ctrl_q.irq_enable;
		tgt       = decode(pins_q.register_select, ctrl_q);
		host_data_wr = acc_start && is_wr && tgt == T_DATA;
		host_data_rd = acc_start && !is_wr && tgt == T_DATA;
		status    = {ctrl_q.pending_n, 1'b0, stop_det_q, 1'b0, gc_lrb_q, aas_q, 1'b0, bb_n_q};
		if (tgt == T_CTRL) begin
			rdata = ctrl_q.serial_enable ? status : ctrl_q;
		end else if (tgt == T_OWN) begin
			rdata = own_q;
		end else if (tgt == T_VEC) begin
			rdata = vec_q;
		end else if (tgt == T_CLK) begin
			rdata = clk_q;
		end else if (tgt == T_DATA) begin
			rdata = rbuf_q;
		end else begin
			rdata = 8'h00;
		end
	end

	// host style detection, sticky until reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			single_q  <= 1'b0;
			wr_prev_q <= 1'b1;
			acc_q     <= 1'b0;
		end else begin
			wr_prev_q <= pins_q.wr_n;
			acc_q     <= acc;
			if (wr_prev_q && !pins_q.wr_n && pins_q.cs_n) begin
				single_q <= 1'b1;
			end
		end
	end

	// setup registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			own_q         <= `OWN_ADDR_RESET;
			clk_q         <= `CLK_REG_RESET;
			vec_q         <= `VEC_RESET_SEP;
			vec_written_q <= 1'b0;
		end else begin
			if (acc_start && is_wr && tgt == T_OWN) begin
				own_q <= pins_q.data;
			end
			if (acc_start && is_wr && tgt == T_CLK) begin
				clk_q <= pins_q.data;
			end
			if (acc_start && is_wr && tgt == T_VEC) begin
				vec_q         <= pins_q.data;
				vec_written_q <= 1'b1;
			end else if (single_q && !vec_written_q) begin
				vec_q <= `VEC_RESET_SINGLE;
			end
		end
	end

	// control register; byte completion clears pending-not and wins over a write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_q <= `CTRL_RESET;
		end else begin
			if (acc_start && is_wr && tgt == T_CTRL) begin
				ctrl_q <= pins_q.data;
			end else if (host_data_wr || host_data_rd) begin
				ctrl_q.pending_n <= 1'b1;
			end
			if (byte_done) begin
				ctrl_q.pending_n <= 1'b0;
			end
		end
	end

	// host bus outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			db_out_q  <= 8'h00;
			db_oe_q   <= 1'b0;
			tack_oe_q <= 1'b0;
			irq_oe_q  <= 1'b0;
		end else begin
			db_out_q  <= irq_acknowledge_n_cyc ? vec_q : rdata;
			db_oe_q   <= irq_acknowledge_n_cyc || (acc && !is_wr);
			tack_oe_q <= single_q && (acc || irq_acknowledge_n_cyc);
			irq_oe_q  <= ctrl_q.irq_enable && !ctrl_q.pending_n;
		end
	end

	// prescaler and scl half-period timer
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pre_cnt_q  <= 6'h00;
			half_cnt_q <= 10'h000;
		end else begin
			pre_cnt_q <= tick ? 6'h00 : pre_cnt_q + 6'h01;
			if (state_q == S_IDLE || state_q == S_HOLD || half_end) begin
				half_cnt_q <= 10'h000;
			end else if (tick) begin
				half_cnt_q <= half_cnt_q + 10'h001;
			end
		end
	end
	assign tick     = pre_cnt_q == pre_div(clk_q[4:2]) - 6'h01;
	assign half_end = tick && half_cnt_q == scl_half(clk_q[1:0]) - 10'h001;

	// digital filter on scl and sda, sampled on the internal tick
	generate
		for (genvar i = 0; i < 2; i++) begin : g_filt
			always_ff @(posedge core_clk) begin
				if (reset) begin
					hist_q[i] <= 1'b1;
					filt_q[i] <= 1'b1;
				end else if (tick) begin
					hist_q[i] <= line_q[i];
					if (hist_q[i] == line_q[i]) begin
						filt_q[i] <= line_q[i];
					end
				end
			end
		end
	endgenerate

	// start/stop watch on the filtered lines
	always_ff @(posedge core_clk) begin
		if (reset) begin
			stop_det_q <= 1'b0;
			bb_n_q     <= 1'b1;
			first_q    <= 1'b0;
		end else begin
			if (acc_start && is_wr && tgt == T_CTRL && pins_q.data[7]) begin
				stop_det_q <= 1'b0;
			end
			// scl must still be high at the line, else an sda change right after scl falls looks like start/stop
			if (tick && filt_q[1] && line_q[1] && hist_q[1] && filt_q[0] && !line_q[0] && hist_q[0] == line_q[0]) begin
				bb_n_q  <= 1'b0;
				first_q <= 1'b1;
			end else if (tick && filt_q[1] && line_q[1] && hist_q[1] && !filt_q[0] && line_q[0]
				&& hist_q[0] == line_q[0]) begin
				bb_n_q     <= 1'b1;
				stop_det_q <= 1'b1;
			end else if (byte_done) begin
				first_q <= 1'b0;
			end
		end
	end

	// byte engine: eight data bits and one acknowledge bit
	assign byte_done = state_q == S_ACKP && half_end && !scl_low_q;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q   <= S_IDLE;
			sh_q      <= 8'h00;
			rbuf_q    <= 8'h00;
			bit_q     <= 3'h0;
			tx_q      <= 1'b0;
			scl_low_q <= 1'b0;
			gc_lrb_q  <= 1'b0;
			aas_q     <= 1'b0;
		end else begin
			if (acc_start && is_wr && tgt == T_CTRL && pins_q.data[7]) begin
				aas_q    <= 1'b0;
				gc_lrb_q <= 1'b0;
			end
			case (state_q)
				S_IDLE, S_HOLD: begin
					scl_low_q <= state_q == S_HOLD;
					if (host_data_wr && ctrl_q.serial_enable) begin
						sh_q      <= pins_q.data;
						tx_q      <= 1'b1;
						bit_q     <= 3'h0;
						scl_low_q <= 1'b1;
						state_q   <= S_SHIFT;
					end else if (host_data_rd && ctrl_q.serial_enable) begin
						tx_q      <= 1'b0;
						bit_q     <= 3'h0;
						scl_low_q <= 1'b1;
						state_q   <= S_SHIFT;
					end
				end
				S_SHIFT: begin
					if (half_end && scl_low_q) begin
						scl_low_q <= 1'b0;
					end else if (half_end) begin
						scl_low_q <= 1'b1;
						sh_q      <= {sh_q[6:0], filt_q[0]};
						bit_q     <= bit_q + 3'h1;
						if (bit_q == 3'h7) begin
							state_q <= S_ACKP;
							if (!tx_q) begin
								rbuf_q <= {sh_q[6:0], filt_q[0]};
							end
							if (!tx_q && first_q && sh_q[6:0] == own_q[6:0]) begin
								aas_q <= 1'b1;
							end
						end
					end
				end
				default: begin
					if (half_end && scl_low_q) begin
						scl_low_q <= 1'b0;
					end else if (half_end) begin
						scl_low_q <= 1'b1;
						gc_lrb_q  <= tx_q ? filt_q[0] : 1'b0;
						state_q   <= S_HOLD;
					end
				end
			endcase
		end
	end

	always_comb begin
		if (state_q == S_SHIFT) begin
			sda_low_q = tx_q && !sh_q[7];
		end else if (state_q == S_ACKP) begin
			sda_low_q = !tx_q && ctrl_q.ack_enable;
		end else begin
			sda_low_q = 1'b0;
		end
	end

	assign db_out             = db_out_q;
	assign db_oe              = db_oe_q;
	assign transfer_ack_n_out = 1'b0;
	assign transfer_ack_n_oe  = tack_oe_q;
	assign irq_out            = 1'b0;
	assign irq_oe             = irq_oe_q;
	assign scl_out            = 1'b0;
	assign scl_oe             = scl_low_q;
	assign sda_out            = 1'b0;
	assign sda_oe             = sda_low_q;

	AST_STYLE: assert property (@(posedge core_clk) disable iff (reset)
		wr_prev_q && !pins_q.wr_n && pins_q.cs_n |=> single_q) else $error("style not switched");
	AST_RESET: assert property (@(posedge core_clk) reset |=> own_q == 8'h00 && clk_q == 8'h00
		&& ctrl_q.pending_n && !aas_q && !stop_det_q) else $error("bad reset state");
	AST_IRQ_ACKNOWLEDGE_N: assert property (@(posedge core_clk) disable iff (reset)
		irq_acknowledge_n_cyc |=> db_oe && db_out == $past(vec_q)) else $error("vector not driven");
	AST_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		state_q == S_HOLD && $past(state_q) == S_HOLD |-> scl_oe) else $error("scl not held");
	AST_COPY: assert property (@(posedge core_clk) disable iff (reset)
		state_q == S_ACKP && !tx_q |-> rbuf_q == sh_q) else $error("buffer not copied");
	AST_TX: assert property (@(posedge core_clk) disable iff (reset)
		host_data_wr && ctrl_q.serial_enable && state_q == S_IDLE |=> state_q == S_SHIFT
		&& sh_q == $past(pins_q.data)) else $error("transmit not started");
	AST_PIN: assert property (@(posedge core_clk) disable iff (reset)
		byte_done |=> !ctrl_q.pending_n ##1 irq_oe == ctrl_q.irq_enable) else $error("pending not cleared");
	AST_VEC: assert property (@(posedge core_clk) disable iff (reset)
		single_q && !vec_written_q && !(acc_start && is_wr && tgt == T_VEC) |=> vec_q == 8'h0F)
		else $error("single vector default");
endmodule // parallel_host_i2c_controller_regs
`default_nettype wire

// ### dv/i2c_target_model.sv
// serial bus target model: open-drain data pull, msb-first data and acknowledge
`timescale 1ns/1ps
`default_nettype none
module i2c_target_model (
	// bus side
	input  wire logic       reset,
	input  wire logic       scl,
	// behaviour
	input  wire logic       tx_en,
	input  wire logic [7:0] tx_byte,
	// open-drain data pull
	output logic            sda_pull
);
	int rises;
	int pos;
	always @(posedge scl or posedge reset) rises <= reset ? 0 : rises + 1;
	always @(negedge scl or posedge reset) pos <= reset ? 0 : rises % 9;
	// drives bits while sending, acknowledges slot nine while listening
	assign sda_pull = tx_en ? (pos < 8 && !tx_byte[7 - pos]) : (pos == 8);
endmodule // i2c_target_model
`default_nettype wire

// ### dv/parallel_host_i2c_controller_regs_tb.sv
// testbench of the parallel host register file and byte engine
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_defs.svh"
module parallel_host_i2c_controller_regs_tb import i2c_ctrl_pkg::*; ;
	logic       core_clk, reset, single, tx_en;
	host_pins_s host_pins;
	logic [7:0] db_out, tx_byte, q, v;
	logic       db_oe, ack_oe, irq_oe, scl_oe, sda_oe, sda_pull;
	wire        scl = !scl_oe;
	wire        sda = !(sda_oe | sda_pull);
	int         err_total, checks_done, cyc, last_rise, per;
	int         mdl[3];
	logic [7:0] sel[3] = '{8'h80, 8'h90, 8'hA0};
	logic       bits[$];
	parallel_host_i2c_controller_regs i_dut (.core_clk(core_clk), .reset(reset), .host_pins(host_pins),
		.db_out(db_out), .db_oe(db_oe), .transfer_ack_n_out(), .transfer_ack_n_oe(ack_oe), .irq_out(),
		.irq_oe(irq_oe), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
	i2c_target_model i_tgt (.reset(reset), .scl(scl), .tx_en(tx_en), .tx_byte(tx_byte), .sda_pull(sda_pull));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc++;
	always @(posedge scl) begin
		bits.push_back(sda);
		per = cyc - last_rise;
		last_rise = cyc;
	end
	task automatic final_report;
		if (err_total == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic a, input logic wr, input logic [7:0] d);
		host_pins.register_select = a;
		host_pins.data = d;
		host_pins.cs_n = 1'b0;
		if (single) host_pins.wr_n = !wr;
		else if (wr) host_pins.wr_n = 1'b0;
		else host_pins.rd_n = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		q = db_out;
		chk("ack_oe", {7'h00, ack_oe}, {7'h00, single});
		chk("db_oe", {7'h00, db_oe}, {7'h00, !wr});
		host_pins.cs_n = 1'b1;
		host_pins.wr_n = 1'b1;
		host_pins.rd_n = 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
	endtask
	task automatic rd(input string nm, input logic a, input logic [7:0] exp);
		acc(a, 1'b0, 8'h00);
		chk(nm, q, exp);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_oe !== 1'b1 && n < 4000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n == 4000) begin
			err_total++;
			final_report;
		end
	endtask
	initial begin
		host_pins = {5'h1D, 8'h00};
		reset = 1'b1;
		single = 1'b0;
		tx_en = 1'b0;
		tx_byte = 8'h00;
		void'($urandom(32'h0FBC));
		repeat (6) @(posedge core_clk);
		#1 reset = 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		for (int i = 0; i < 3; i++) begin
			acc(1'b1, 1'b1, sel[i]);
			rd("control", 1'b1, sel[i]);
			rd("setup reset", 1'b0, 8'h00);
			mdl[i] = $urandom & 32'hFF;
			acc(1'b0, 1'b1, mdl[i][7:0]);
		end
		for (int i = 0; i < 3; i++) begin
			acc(1'b1, 1'b1, sel[i]);
			rd("setup", 1'b0, mdl[i][7:0]);
		end
		acc(1'b1, 1'b1, 8'hB0);
		acc(1'b0, 1'b1, 8'h5A);
		rd("unmapped", 1'b0, 8'h00);
		acc(1'b1, 1'b1, 8'h88);
		host_pins.irq_acknowledge_n = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		chk("vector", db_out, mdl[1][7:0]);
		chk("vector oe", {7'h00, db_oe}, 8'h01);
		host_pins.irq_acknowledge_n = 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		acc(1'b1, 1'b1, 8'hA0);
		acc(1'b0, 1'b1, 8'h00);
		acc(1'b1, 1'b1, 8'hC9);
		v = $urandom;
		bits.delete();
		acc(1'b0, 1'b1, v);
		wait_irq();
		for (int k = 0; k < 8; k++) q = {q[6:0], bits[k]};
		chk("tx byte", q, v);
		chk("scl period", per[7:0], 8'(2 * `SCL_HALF_90K * `PRE_DIV_3M));
		chk("scl hold", {7'h00, scl_oe}, 8'h01);
		acc(1'b1, 1'b0, 8'h00);
		chk("status", q & 8'hFE, 8'h00);
		tx_byte = $urandom;
		tx_en = 1'b1;
		acc(1'b0, 1'b0, 8'h00);
		wait_irq();
		rd("rx byte", 1'b0, tx_byte);
		host_pins.wr_n = 1'b0;
		repeat (4) @(posedge core_clk);
		#1 host_pins.wr_n = 1'b1;
		repeat (6) @(posedge core_clk);
		#1 single = 1'b1;
		acc(1'b1, 1'b0, 8'h00);
		final_report;
	end
endmodule // parallel_host_i2c_controller_regs_tb
`default_nettype wire
